// ===== typec_port_pkg.sv
// Shared types and constants for the Type-C source port control logic
package typec_port_pkg;

    // ------------------------------------------------------------
    // Select codes
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_RESERVED = 2'h0;
    localparam logic [1:0] SEL_DCP_AUTO = 2'h1;
    localparam logic [1:0] SEL_SDP      = 2'h2;
    localparam logic [1:0] SEL_CDP      = 2'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_HZ     = 20000000;
    localparam int DEBOUNCE_US     = 100;
    localparam int DEBOUNCE_CYCLES = (CLK_FREQ_HZ / 1000000) * DEBOUNCE_US;

    // ------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ADV_OFF,
        ADV_1A5,
        ADV_3A
    } adv_level_type;

    typedef enum logic [1:0] {
        MODE_NONE,
        MODE_SDP,
        MODE_CDP,
        MODE_DCP_AUTO
    } charge_mode_type;

    // Analog status from comparators (asynchronous to the clock)
    typedef struct packed {
        logic cc1_rd;
        logic cc1_ra;
        logic cc2_rd;
        logic cc2_ra;
        logic die_hot;
        logic die_cool;
        logic ntc_warn;
        logic ntc_shut;
    } sense_type;

    localparam int          SENSE_W          = 8;
    localparam logic [1:0]  ILIM_RESET       = 2'h0;
    localparam logic [1:0]  ILIM_1A5         = 2'h1;
    localparam logic [1:0]  ILIM_3A          = 2'h2;

endpackage

// ===== typec_source_port_control.sv
// Type-C source port control: select decode, power wake, thermal and orientation
// ------------------------------------------------------------
// Functional notes
// - Decode select pins into advertisement and mode
// - Current limit setting follows advertisement
// - Data switch routes D+/D- on base (non-thermistor) variant, SDP and CDP only
// - Orientation flag low for sink on CC2
// - Flag released when no sink attached
// - Regulator off until sink detected
// - Die overtemperature stops regulator and gate
// - Restart automatically after die cools
// - Thermistor warning lowers 3 A to 1.5 A
// - Warning flag set, fault not asserted
// - Thermistor shutdown stops regulator and gate
// - Warning stays asserted during thermistor shutdown
// - Enable only after debounced stable detection
// - VCONN onto pin seeing cable termination
// - Rd/Rd or Ra/Ra is unsupported, regulator, gate and VCONN off
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module typec_source_port_control
    import typec_port_pkg::*;
#(
    parameter bit NTC_VARIANT     = 1'b0,
    parameter int DEBOUNCE_CNT    = DEBOUNCE_CYCLES
) (
    // Clock and reset
    input  wire logic                        core_clk_in,
    input  wire logic                        rst_n_in,
    // Select pins (static straps)
    input  wire logic                        charge_select_a_in,
    input  wire logic                        charge_select_b_in,
    // Comparator status
    input  wire typec_port_pkg::sense_type   sense_in,
    // Power control
    output logic                             buck_enable_out,
    output logic                             load_switch_gate_out,
    output logic                             vconn_cc1_out,
    output logic                             vconn_cc2_out,
    // Advertisement and limit
    output typec_port_pkg::adv_level_type    cc_adv_out,
    output typec_port_pkg::charge_mode_type  charge_mode_out,
    output logic [1:0]                       ilim_sel_out,
    // Data path
    output logic                             data_switch_on_out,
    // Flags
    output logic                             orientation_flag_n_out,
    output logic                             orientation_flag_n_oe_n_out,
    output logic                             overheat_warning_out,
    output logic                             fault_out
);
    import typec_port_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (DEBOUNCE_CNT < 1 || DEBOUNCE_CNT > 65535) begin : g_bad_debounce
        $error("DEBOUNCE_CNT out of range");
    end

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [SENSE_W+1:0] meta_r;
    logic [SENSE_W+1:0] sync_r;
    logic [SENSE_W+1:0] raw_in;
    sense_type          s;
    logic [1:0]         sel;

    assign raw_in = {charge_select_a_in, charge_select_b_in, sense_in};

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= raw_in;
            sync_r <= meta_r;
        end
    end

    assign s   = sense_type'(sync_r[SENSE_W-1:0]);
    assign sel = sync_r[SENSE_W+1:SENSE_W];

    // ------------------------------------------------------------
    // Attach classification and debounce
    // ------------------------------------------------------------
    logic        attach_raw;
    logic        sink_on_cc2;
    logic        attach_prev_r;
    logic        attach_prev_nxt;
    logic        cc2_prev_r;
    logic        cc2_prev_nxt;
    logic [15:0] deb_cnt_r;
    logic [15:0] deb_cnt_nxt;
    logic        attached_r;
    logic        attached_nxt;
    logic        cc2_r;
    logic        cc2_nxt;

    always_comb begin
        // Exactly one Rd; Rd/Rd and Ra/Ra never count as attached
        attach_raw  = (s.cc1_rd ^ s.cc2_rd);
        sink_on_cc2 = s.cc2_rd && !s.cc1_rd;
        attach_prev_nxt = attach_raw;
        cc2_prev_nxt    = sink_on_cc2;
        deb_cnt_nxt     = deb_cnt_r;
        attached_nxt    = attached_r;
        cc2_nxt         = cc2_r;
        if (attach_raw != attach_prev_r || sink_on_cc2 != cc2_prev_r) begin
            deb_cnt_nxt = 16'h0000;
        end else if (deb_cnt_r < 16'(DEBOUNCE_CNT - 1)) begin
            deb_cnt_nxt = deb_cnt_r + 16'h0001;
        end else begin
            // Stable long enough: adopt new attach state
            attached_nxt = attach_raw;
            cc2_nxt      = sink_on_cc2;
        end
        if (!attach_raw) begin
            // Detach drops power at once; only attach is debounced
            attached_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            attach_prev_r <= 1'b0;
            cc2_prev_r    <= 1'b0;
            deb_cnt_r     <= 16'h0000;
            attached_r    <= 1'b0;
            cc2_r         <= 1'b0;
        end else begin
            attach_prev_r <= attach_prev_nxt;
            cc2_prev_r    <= cc2_prev_nxt;
            deb_cnt_r     <= deb_cnt_nxt;
            attached_r    <= attached_nxt;
            cc2_r         <= cc2_nxt;
        end
    end

    // ------------------------------------------------------------
    // Thermal state
    // ------------------------------------------------------------
    logic die_off_r;
    logic die_off_nxt;

    always_comb begin
        die_off_nxt = die_off_r;
        if (s.die_hot) begin
            die_off_nxt = 1'b1;
        end else if (s.die_cool) begin
            // Cool comparator sits about 20 C below trip point
            die_off_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            die_off_r <= 1'b0;
        end else begin
            die_off_r <= die_off_nxt;
        end
    end

    // ------------------------------------------------------------
    // Output decode
    // ------------------------------------------------------------
    logic            ntc_warn;
    logic            ntc_shut;
    logic            sel_valid;
    logic            power_on;
    adv_level_type   adv_nxt;
    charge_mode_type mode_nxt;
    logic [1:0]      ilim_nxt;
    logic            data_nxt;
    logic            vconn1_nxt;
    logic            vconn2_nxt;
    logic            pol_oe_n_nxt;

    always_comb begin
        ntc_warn  = NTC_VARIANT && (s.ntc_warn || s.ntc_shut);
        ntc_shut  = NTC_VARIANT && s.ntc_shut;
        // Reserved codes are the board's fault; treat them as port off
        sel_valid = sel[1] || (NTC_VARIANT && sel == SEL_DCP_AUTO);
        mode_nxt  = MODE_NONE;
        adv_nxt   = ADV_OFF;
        if (sel == SEL_SDP) begin
            mode_nxt = MODE_SDP;
            adv_nxt  = ADV_1A5;
        end else if (sel == SEL_CDP) begin
            mode_nxt = MODE_CDP;
            adv_nxt  = ADV_3A;
        end else if (NTC_VARIANT && sel == SEL_DCP_AUTO) begin
            mode_nxt = MODE_DCP_AUTO;
            adv_nxt  = ADV_3A;
        end
        if (ntc_warn && adv_nxt == ADV_3A) begin
            // Restored automatically once both the warning and shutdown comparators drop
            adv_nxt = ADV_1A5;
        end
        ilim_nxt = (adv_nxt == ADV_3A) ? ILIM_3A :
                   (adv_nxt == ADV_1A5) ? ILIM_1A5 : ILIM_RESET;
        // Stub-only path on the thermistor variant
        data_nxt = !NTC_VARIANT && sel[1];
        power_on = attached_r && sel_valid && !die_off_r && !ntc_shut;
        vconn1_nxt = power_on && cc2_r && s.cc1_ra;
        vconn2_nxt = power_on && !cc2_r && s.cc2_ra;
        // Live side term releases the flag at once when CC2 loses its sink
        pol_oe_n_nxt = !(attached_r && cc2_r && sink_on_cc2);
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            buck_enable_out             <= 1'b0;
            load_switch_gate_out        <= 1'b0;
            vconn_cc1_out               <= 1'b0;
            vconn_cc2_out               <= 1'b0;
            cc_adv_out                  <= ADV_OFF;
            charge_mode_out             <= MODE_NONE;
            ilim_sel_out                <= ILIM_RESET;
            data_switch_on_out          <= 1'b0;
            orientation_flag_n_out      <= 1'b0;
            orientation_flag_n_oe_n_out <= 1'b1;
            overheat_warning_out        <= 1'b0;
            fault_out                   <= 1'b0;
        end else begin
            buck_enable_out             <= power_on;
            load_switch_gate_out        <= power_on;
            vconn_cc1_out               <= vconn1_nxt;
            vconn_cc2_out               <= vconn2_nxt;
            cc_adv_out                  <= adv_nxt;
            charge_mode_out             <= mode_nxt;
            ilim_sel_out                <= ilim_nxt;
            data_switch_on_out          <= data_nxt;
            orientation_flag_n_out      <= 1'b0;
            orientation_flag_n_oe_n_out <= pol_oe_n_nxt;
            overheat_warning_out        <= ntc_warn;
            // Thermistor events never raise fault; only die shutdown does
            fault_out                   <= die_off_r;
        end
    end

endmodule

`default_nettype wire

// ===== port_checks_assertions.sv
// Concurrent checks on the source port control ports
`timescale 1ns/1ps
`default_nettype none
module port_checks
    import typec_port_pkg::*;
#(
    parameter bit NTC_VARIANT  = 1'b0,
    parameter int DEBOUNCE_CNT = 4
) (
    // Inputs
    input wire logic       core_clk_in,
    input wire logic       rst_n_in,
    input wire logic       charge_select_a_in,
    input wire logic       charge_select_b_in,
    input wire sense_type  sense_in,
    // Outputs
    input wire logic       buck_enable_out,
    input wire logic       load_switch_gate_out,
    input wire logic       vconn_cc1_out,
    input wire logic       vconn_cc2_out,
    input wire adv_level_type cc_adv_out,
    input wire logic [1:0] ilim_sel_out,
    input wire logic       orientation_flag_n_oe_n_out,
    input wire logic       overheat_warning_out,
    input wire logic       fault_out
);
    logic [1:0]  rd_r, rd_nxt;
    logic [15:0] stab_r, stab_nxt;
    // Run length of one steady Rd; saturates so it never wraps
    always_comb begin
        rd_nxt   = {sense_in.cc1_rd, sense_in.cc2_rd};
        stab_nxt = (rd_nxt == rd_r && ^rd_nxt) ? stab_r + {15'h0, ~&stab_r} : 16'h0;
    end
    always_ff @(posedge core_clk_in) begin
        rd_r   <= rst_n_in ? rd_nxt : 2'h0;
        stab_r <= rst_n_in ? stab_nxt : 16'h0;
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_power_needs_sink: assert property ((sense_in.cc1_rd == sense_in.cc2_rd)[*5] |->
        !buck_enable_out && !load_switch_gate_out && !vconn_cc1_out && !vconn_cc2_out)
        else $error("power on without a single sink");
    a_debounce_first: assert property ($rose(buck_enable_out) |-> stab_r >= DEBOUNCE_CNT)
        else $error("regulator on before debounce");
    a_die_hot_off: assert property (sense_in.die_hot[*6] |->
        !buck_enable_out && !load_switch_gate_out && fault_out)
        else $error("die hot but power on");
    a_fault_until_cool: assert property (fault_out && !sense_in.die_cool |=> fault_out)
        else $error("restart before cooling");
    a_ntc_shut_off: assert property ((NTC_VARIANT && sense_in.ntc_shut)[*5] |->
        !buck_enable_out && !load_switch_gate_out && overheat_warning_out && !fault_out)
        else $error("thermistor shutdown wrong");
    a_warn_derates: assert property ((NTC_VARIANT && sense_in.ntc_warn && charge_select_a_in
        && charge_select_b_in)[*5] |-> cc_adv_out == ADV_1A5 && overheat_warning_out)
        else $error("warning did not derate");
    a_limit_matches: assert property (cc_adv_out == ADV_3A |-> ilim_sel_out == ILIM_3A)
        else $error("limit differs from advert");
    a_orient_release: assert property ((!sense_in.cc2_rd)[*5] |-> orientation_flag_n_oe_n_out)
        else $error("flag pulled without CC2 sink");
    c_power_on: cover property ($rose(buck_enable_out));
    c_die_fault: cover property ($rose(fault_out));
    c_derated: cover property (overheat_warning_out && cc_adv_out == ADV_1A5);
endmodule
bind typec_source_port_control port_checks #(.NTC_VARIANT(NTC_VARIANT),
    .DEBOUNCE_CNT(DEBOUNCE_CNT)) u_chk (.*);
`default_nettype wire

// ===== sink_model.sv
// Sink and cable model giving CC comparator levels
`timescale 1ns/1ps
`default_nettype none
module sink_model (
    // Terminations: 0 open, 1 Rd, 2 Ra
    input  wire logic [1:0] cc1_term_in,
    input  wire logic [1:0] cc2_term_in,
    // Levels {cc1_rd, cc1_ra, cc2_rd, cc2_ra}
    output logic      [3:0] cc_out
);
    // Open pin shows neither level
    assign cc_out = {cc1_term_in == 2'h1, cc1_term_in == 2'h2,
                     cc2_term_in == 2'h1, cc2_term_in == 2'h2};
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the source port control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import typec_port_pkg::*;
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin mismatches++; \
    $display("[FAIL] %s expected %h seen %h", n, e, s); end end
    localparam logic [1:0] OPN = 2'h0, RD = 2'h1, RA = 2'h2;
    logic core_clk_in, rst_n_in, sel_a, sel_b, buck, gate, v1, v2, fl, fl_oe_n, warn, flt, dsw;
    logic [1:0] t1, t2, ilim;
    logic [3:0] therm, cc;
    logic [12:0] note_q[$];
    logic [12:0] x, obs;
    adv_level_type adv;
    charge_mode_type mode;
    sense_type sense;
    int mismatches = 0;
    int total_checks = 0;
    event got;
    assign sense = sense_type'({cc, therm});
    assign obs = {buck, gate, v1, v2, adv, mode, ilim, fl_oe_n, warn, flt};
    sink_model u_sink (.cc1_term_in(t1), .cc2_term_in(t2), .cc_out(cc));
    typec_source_port_control #(.NTC_VARIANT(1'b1), .DEBOUNCE_CNT(4)) u_dut (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .charge_select_a_in(sel_a),
        .charge_select_b_in(sel_b), .sense_in(sense), .buck_enable_out(buck),
        .load_switch_gate_out(gate), .vconn_cc1_out(v1), .vconn_cc2_out(v2),
        .cc_adv_out(adv), .charge_mode_out(mode), .ilim_sel_out(ilim),
        .data_switch_on_out(dsw), .orientation_flag_n_out(fl),
        .orientation_flag_n_oe_n_out(fl_oe_n), .overheat_warning_out(warn), .fault_out(flt));
    function automatic logic [12:0] ex(input logic p, c1, c2, input logic [1:0] a, m, l,
        input logic o, w, f);
        return {p, p, c1, c2, a, m, l, o, w, f};
    endfunction
    task automatic step(input logic [1:0] s, c1, c2, input logic [3:0] th, input logic [12:0] e);
        @(negedge core_clk_in);
        {sel_a, sel_b} = s;
        t1 = c1;
        t2 = c2;
        therm = th;
        repeat (16) @(negedge core_clk_in);
        note_q.push_back(e);
        -> got;
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end
    initial forever begin
        @(got);
        x = note_q.pop_front();
        `CHK("power", x[12:11], obs[12:11])
        `CHK("vconn", x[10:9], obs[10:9])
        `CHK("advert", x[8:7], obs[8:7])
        `CHK("mode", x[6:5], obs[6:5])
        `CHK("limit", x[4:3], obs[4:3])
        `CHK("orient", x[2], obs[2])
        `CHK("warn", x[1], obs[1])
        `CHK("fault", x[0], obs[0])
        `CHK("flag_data", 1'b0, fl)
        `CHK("data_path", 1'b0, dsw)
    end
    initial begin
        #60000;
        mismatches++;
        complete_run;
    end
    initial begin
        logic [1:0] s;
        void'($urandom(32'h8b279495));
        {rst_n_in, sel_a, sel_b, t1, t2, therm} = {3'h2, 8'h0};
        repeat (2) @(negedge core_clk_in);
        rst_n_in = 1'b1;
        step(SEL_SDP, OPN, OPN, 4'h0, ex('0, '0, '0, ADV_1A5, MODE_SDP, ILIM_1A5, '1, '0, '0));
        // Code 00 is never driven; last pass takes a random valid code
        for (int i = 1; i <= 4; i++) begin
            s = (i < 4) ? 2'(i) : 2'(1 + $urandom % 3);
            step(s, OPN, RD, 4'h0, ex('1, '0, '0, s == SEL_SDP ? ADV_1A5 : ADV_3A,
                s == SEL_SDP ? MODE_SDP : (s == SEL_CDP ? MODE_CDP : MODE_DCP_AUTO),
                s == SEL_SDP ? ILIM_1A5 : ILIM_3A, '0, '0, '0));
        end
        step(SEL_CDP, RD, RA, 4'h0, ex('1, '0, '1, ADV_3A, MODE_CDP, ILIM_3A, '1, '0, '0));
        step(SEL_CDP, RA, RD, 4'h0, ex('1, '1, '0, ADV_3A, MODE_CDP, ILIM_3A, '0, '0, '0));
        step(SEL_CDP, RD, RD, 4'h0, ex('0, '0, '0, ADV_3A, MODE_CDP, ILIM_3A, '1, '0, '0));
        step(SEL_CDP, RA, RA, 4'h0, ex('0, '0, '0, ADV_3A, MODE_CDP, ILIM_3A, '1, '0, '0));
        step(SEL_CDP, RD, OPN, 4'h2, ex('1, '0, '0, ADV_1A5, MODE_CDP, ILIM_1A5, '1, '1, '0));
        step(SEL_CDP, RD, OPN, 4'h3, ex('0, '0, '0, ADV_1A5, MODE_CDP, ILIM_1A5, '1, '1, '0));
        step(SEL_CDP, RD, OPN, 4'h0, ex('1, '0, '0, ADV_3A, MODE_CDP, ILIM_3A, '1, '0, '0));
        // Die trip holds off until the cool comparator reports
        step(SEL_CDP, RD, OPN, 4'h8, ex('0, '0, '0, ADV_3A, MODE_CDP, ILIM_3A, '1, '0, '1));
        step(SEL_CDP, RD, OPN, 4'h0, ex('0, '0, '0, ADV_3A, MODE_CDP, ILIM_3A, '1, '0, '1));
        step(SEL_CDP, RD, OPN, 4'h4, ex('1, '0, '0, ADV_3A, MODE_CDP, ILIM_3A, '1, '0, '0));
        rst_n_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
        note_q.push_back(ex('0, '0, '0, ADV_OFF, MODE_NONE, ILIM_RESET, '1, '0, '0));
        -> got;
        @(negedge core_clk_in);
        rst_n_in = 1'b1;
        step(SEL_SDP, OPN, RD, 4'h0, ex('1, '0, '0, ADV_1A5, MODE_SDP, ILIM_1A5, '0, '0, '0));
        // Let the watcher take the last note before ending
        @(negedge core_clk_in);
        complete_run;
    end
endmodule
`default_nettype wire
